/* File: farp_pkg.sv */
// How it works
// - restart only after clean self-diagnosis
// - only listed fault classes may auto-restart
// - undervoltage eligible only with ride-through 1/2
// - other faults trip, never restart
// - retry every 5 ms within window, one attempt
// - attempt limit 0..10, default 0, speed search
// - retry window 0.5..180 s, default 10 s
// - relay select bit drives fault contact during restart
// - clear attempt count after 10 fault-free minutes
// - clear count on error reset in trip state, power cycle
// - relay function 1E shows restart in progress
// - heatsink trip level switches output off
// - pre-alarm at threshold 50..130 C, default 95
// - pre-alarm reaction select 0..4, default 4
// - reactions 0-2 fault, 3 minor fault
// - reduction limits speed to 0..20 percent
// - relay function 20 shows heatsink pre-alarm
// - ripple sum over 10 scans raises phase fault
// - ripple threshold percent of 400/800 V trip
// - phase current sum detects earth leakage
// - leakage detection enable bit, default on
package farp_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned RETRY_PERIOD_US = 5000;
  localparam int unsigned RETRY_PERIOD_CYC = RETRY_PERIOD_US * (CLK_HZ / 1000000);
  localparam int unsigned TENTH_S_CYC = CLK_HZ / 10;
  localparam int unsigned RUN_OK_MIN = 10;
  localparam int unsigned RUN_OK_TENTHS = RUN_OK_MIN * 600;
  localparam int unsigned SCAN_WINDOW = 10;
  // register byte offsets
  localparam logic [7:0] OFS_RESTART = 8'h00;
  localparam logic [7:0] OFS_HEAT = 8'h04;
  localparam logic [7:0] OFS_PROTECT = 8'h08;
  localparam logic [7:0] OFS_RELAY = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  // parameter defaults and limits
  localparam logic [3:0] ATTEMPT_DEF = 4'h0;
  localparam logic [3:0] ATTEMPT_MAX = 4'ha;
  localparam logic [10:0] WINDOW_DEF = 11'h064; // tenths of a second
  localparam logic [10:0] WINDOW_MIN = 11'h005;
  localparam logic [10:0] WINDOW_MAX = 11'h708;
  localparam logic [7:0] PRE_TEMP_DEF = 8'h5f;
  localparam logic [7:0] PRE_TEMP_MIN = 8'h32;
  localparam logic [7:0] PRE_TEMP_MAX = 8'h82;
  localparam logic [2:0] REACT_DEF = 3'h4;
  localparam logic [7:0] SPEED_LIM_DEF = 8'hc8; // tenths of a percent
  localparam logic [7:0] SPEED_LIM_MAX = 8'hc8;
  localparam logic [7:0] RIPPLE_DEF = 8'h32; // tenths of a percent
  localparam logic [7:0] RIPPLE_MAX = 8'hfa;
  localparam logic [11:0] OV_TRIP_LOW = 12'h190; // volts
  localparam logic [11:0] OV_TRIP_HIGH = 12'h320;
  localparam logic [9:0] PERMILLE = 10'h3e8;
  localparam logic [7:0] FUNC_RESTART = 8'h1e;
  localparam logic [7:0] FUNC_PREALARM = 8'h20;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // fault bit positions
  localparam int unsigned F_OC = 0;
  localparam int unsigned F_GF = 1;
  localparam int unsigned F_PUF = 2;
  localparam int unsigned F_OV = 3;
  localparam int unsigned F_UV = 4;
  localparam int unsigned F_PF = 5;
  localparam int unsigned F_OL1 = 6;
  localparam int unsigned F_OL2 = 7;
  localparam int unsigned F_OH1 = 8;
  localparam int unsigned F_OL3 = 9;
  localparam int unsigned NFAULT = 16;
  localparam logic [15:0] ELIGIBLE_MASK = 16'h03ef;
  typedef enum logic [1:0]
  {
    FARP_RUN = 2'b00,
    FARP_RETRY = 2'b01,
    FARP_TRIP = 2'b10
  } farp_state_e;
  typedef enum logic [2:0]
  {
    FARP_RAMP = 3'b000,
    FARP_COAST = 3'b001,
    FARP_FAST = 3'b010,
    FARP_SHOW = 3'b011,
    FARP_REDUCE = 3'b100
  } farp_react_e;
endpackage : farp_pkg

/* File: farp_plant.sv */
`timescale 1ns/10ps
// power stage and phase current sensors on the far side of the block
module farp_plant (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // commands from the supervisor
  input wire logic output_off,
  input wire logic stop_req,
  input wire logic restart_req,
  // leakage share injected by the bench
  input wire logic signed [15:0] leak,
  // drive status and currents
  output logic running,
  output logic diag_ok,
  output logic signed [15:0] cur_u,
  output logic signed [15:0] cur_v,
  output logic signed [15:0] cur_w
);
  typedef struct packed {
    logic run;
  } farp_plant_s;
  farp_plant_s st;
  farp_plant_s next_st;
  // motor stops when the output is cut or a stop is asked, resumes on restart
  always_comb
  begin
    next_st = st;
    if (output_off || stop_req)
      next_st.run = 1'b0;
    if (restart_req)
      next_st.run = 1'b1;
  end
  // running from power-up
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '{run: 1'b1};
    else
      st <= next_st;
  end
  assign running = st.run;
  // self-test of the power stage always finds it healthy
  assign diag_ok = 1'b1;
  // balanced three-phase set, so the sum equals the leakage share
  assign cur_u = 16'sh03e8;
  assign cur_v = 16'shfe0c;
  assign cur_w = 16'shfe0c + leak;
endmodule : farp_plant

/* File: farp_ripple.sv */
`timescale 1ns/10ps
// sliding sum of the last ten ripple samples against a limit
module farp_ripple #(
  parameter int unsigned DEPTH = 10,
  parameter int unsigned W = 12
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // samples
  input wire logic scan,
  input wire logic [W-1:0] ripple,
  input wire logic [W+3:0] limit,
  // result
  output logic over
);
  import farp_pkg::*;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] hist;
    logic [W+3:0] sum;
    logic [3:0] fill;
    logic over;
  } farp_rip_s;
  farp_rip_s r;
  farp_rip_s next_r;
  // shift in a sample, keep running sum
  always_comb
  begin
    next_r = r;
    if (scan)
    begin
      next_r.hist = {r.hist[DEPTH-2:0], ripple};
      next_r.sum = r.sum + (W+4)'(ripple) - (W+4)'(r.hist[DEPTH-1]);
      if (r.fill != 4'(DEPTH))
        next_r.fill = r.fill + 4'h1;
    end
    next_r.over = (r.fill == 4'(DEPTH)) && (r.sum > limit);
  end
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      r <= '0;
    else
      r <= next_r;
  end
  assign over = r.over;
  a_ripple_flag: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (r.fill == 4'(DEPTH) && r.sum > limit) |=> over) else $error("ripple over missed");
endmodule : farp_ripple

/* File: farp_tb_top.sv */
`timescale 1ns/10ps
// self-checking bench for the fault supervision block
module farp_tb_top;
  import farp_pkg::*;
  logic REF_CLK, ARST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, RUNNING, DIAG_OK, ERROR_RESET, HIGH_CLASS;
  logic HEATSINK_TRIP, RIPPLE_SCAN, OUTPUT_OFF, RESTART_REQ, SPEED_SEARCH, STOP_REQ;
  logic MINOR_FAULT, SPEED_LIMIT_EN, FAULT_CONTACT, RELAY_A, RELAY_B;
  logic [7:0] AWADDR, ARADDR, HEATSINK_TEMP, SPEED_LIMIT;
  logic [31:0] WDATA, RDATA, rd_val;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, rd_resp;
  logic [NFAULT-1:0] FAULT_IN;
  logic [11:0] RIPPLE_VOLT;
  logic [2:0] STOP_MODE;
  logic signed [15:0] CUR_U, CUR_V, CUR_W, leak;
  int num_errors, n_compared;
  // device under test and its power stage
  farp_top uut (.REF_CLK, .ARST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY, .RUNNING, .FAULT_IN, .DIAG_OK, .ERROR_RESET, .HIGH_CLASS,
    .HEATSINK_TEMP, .HEATSINK_TRIP, .RIPPLE_SCAN, .RIPPLE_VOLT, .CUR_U, .CUR_V, .CUR_W,
    .OUTPUT_OFF, .RESTART_REQ, .SPEED_SEARCH, .STOP_MODE, .STOP_REQ, .MINOR_FAULT,
    .SPEED_LIMIT_EN, .SPEED_LIMIT, .FAULT_CONTACT, .RELAY_A, .RELAY_B);
  farp_plant model (.ref_clk(REF_CLK), .arst_n(ARST_N), .output_off(OUTPUT_OFF),
    .stop_req(STOP_REQ), .restart_req(RESTART_REQ), .leak(leak), .running(RUNNING),
    .diag_ok(DIAG_OK), .cur_u(CUR_U), .cur_v(CUR_V), .cur_w(CUR_W));
  // 40 MHz reference clock
  initial REF_CLK = 1'b0;
  always #12.5 REF_CLK = ~REF_CLK;
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // power cycle: reset low for six clocks
  task hw_reset;
    @(posedge REF_CLK);
    ARST_N <= 1'b0;
    repeat (6) @(posedge REF_CLK);
    ARST_N <= 1'b1;
  endtask : hw_reset
  // write one word; handshakes are sampled mid-cycle and released on the edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, done;
    done = 1'b0;
    @(posedge REF_CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!done)
    begin
      @(negedge REF_CLK);
      done = BVALID;
      rd_resp = BRESP;
      aw_hs = AWVALID && AWREADY;
      w_hs = WVALID && WREADY;
      @(posedge REF_CLK);
      if (aw_hs)
        AWVALID <= 1'b0;
      if (w_hs)
        WVALID <= 1'b0;
    end
    BREADY <= 1'b0;
  endtask : wr
  // read one word into rd_val and rd_resp
  task rd(input logic [7:0] a);
    logic hs, done;
    done = 1'b0;
    @(posedge REF_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!done)
    begin
      @(negedge REF_CLK);
      done = RVALID;
      rd_val = RDATA;
      rd_resp = RRESP;
      hs = ARVALID && ARREADY;
      @(posedge REF_CLK);
      if (hs)
        ARVALID <= 1'b0;
    end
    RREADY <= 1'b0;
  endtask : rd
  // read and compare the masked word
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_val & m, e);
  endtask : rdc
  // one-cycle fault pulse, then let the state settle
  task fault(input int b);
    @(posedge REF_CLK);
    FAULT_IN <= 16'h0001 << b;
    @(posedge REF_CLK);
    FAULT_IN <= 16'h0000;
    repeat (4) @(posedge REF_CLK);
  endtask : fault
  // fresh block, restart settings, one fault, state and attempt count
  task fault_case(input logic [31:0] cfg, input int b, input logic [31:0] e);
    hw_reset();
    wr(OFS_RESTART, cfg);
    fault(b);
    rdc(OFS_STATUS, 32'h0000_0f03, e);
  endtask : fault_case
  // ripple scans of one level, back to back
  task scans(input int n, input logic [11:0] v);
    repeat (n)
    begin
      @(posedge REF_CLK);
      RIPPLE_VOLT <= v;
      RIPPLE_SCAN <= 1'b1;
      @(posedge REF_CLK);
      RIPPLE_SCAN <= 1'b0;
    end
    repeat (3) @(posedge REF_CLK);
  endtask : scans
  // ten scans right at the limit, then one step over it
  task ripple_case(input logic hc, input logic [11:0] v);
    hw_reset();
    HIGH_CLASS <= hc;
    scans(10, v);
    rdc(OFS_STATUS, 32'h8, 32'h0);
    scans(1, v + 12'h001);
    rdc(OFS_STATUS, 32'h8, 32'h8);
  endtask : ripple_case
  // verdict
  task close_out;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  // main sequence
  initial
  begin
    {ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, ERROR_RESET} = '0;
    {HIGH_CLASS, HEATSINK_TRIP, RIPPLE_SCAN, AWADDR, ARADDR, WDATA} = '0;
    {FAULT_IN, RIPPLE_VOLT, leak, num_errors, n_compared} = '0;
    WSTRB = 4'hf;
    HEATSINK_TEMP = 8'h19;
    hw_reset();
    rdc(OFS_RESTART, '1, 32'h0000_6400);
    rdc(OFS_HEAT, '1, 32'h00c8_045f);
    rdc(OFS_PROTECT, '1, 32'hffff_0132);
    rd(8'h20);
    chk(rd_resp, AXI_SLVERR);
    chk(rd_val, 32'h0);
    wr(OFS_RESTART, 32'h0000_010f);
    rdc(OFS_RESTART, '1, 32'h0000_050a);
    wr(OFS_HEAT, 32'h00ff_04ff);
    rdc(OFS_HEAT, '1, 32'h00c8_0482);
    wr(8'h40, 32'h1);
    chk(rd_resp, AXI_SLVERR);
    // every fault class, eligible ones enter retry as one attempt
    for (int b = 0; b < 16; b++)
      fault_case(32'h0010_6402, b, (b < 10) ? 32'h101 : 32'h002);
    for (int rs = 0; rs < 3; rs++)
      fault_case(32'h0000_6402 | (32'(rs) << 20), F_UV, (rs == 0) ? 32'h2 : 32'h101);
    fault_case(32'h0000_6400, F_OC, 32'h2);
    fault_case(32'h0000_6400, 12, 32'h2);
    rdc(OFS_STATUS, 32'hffff_0000, 32'h1000_0000);
    ERROR_RESET <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    ERROR_RESET <= 1'b0;
    rdc(OFS_STATUS, 32'hffff_0f03, 32'h0);
    // restart indication on relay a and the fault contact
    for (int s = 0; s < 2; s++)
    begin
      hw_reset();
      wr(OFS_RELAY, 32'h0000_201e);
      wr(OFS_RESTART, 32'h0000_6402 | (32'(s) << 4));
      @(negedge REF_CLK);
      chk(RELAY_A, 1'b0);
      fault(F_OC);
      @(negedge REF_CLK);
      chk(RELAY_A, 1'b1);
      chk(FAULT_CONTACT, 32'(s));
      chk(RESTART_REQ, 1'b0);
      chk(SPEED_SEARCH, 1'b0);
    end
    // heatsink pre-alarm under each reaction
    for (int r = 0; r < 5; r++)
    begin
      hw_reset();
      wr(OFS_RELAY, 32'h0000_2000);
      wr(OFS_HEAT, 32'h00c8_005f | (32'(r) << 8));
      HEATSINK_TEMP <= 8'h5e;
      rdc(OFS_STATUS, 32'h20, 32'h0);
      @(negedge REF_CLK);
      chk(RELAY_B, 1'b0);
      @(posedge REF_CLK);
      HEATSINK_TEMP <= 8'h60;
      repeat (3) @(posedge REF_CLK);
      @(negedge REF_CLK);
      chk(RELAY_B, 1'b1);
      chk(STOP_REQ, r < 3);
      chk(MINOR_FAULT, r == 3);
      chk(FAULT_CONTACT, r < 3);
      chk(SPEED_LIMIT_EN, r == 4);
      if (r < 3)
        chk(STOP_MODE, 32'(r));
      if (r == 4)
        chk(SPEED_LIMIT, 8'hc8);
      @(posedge REF_CLK);
      HEATSINK_TEMP <= 8'h5f;
      rdc(OFS_STATUS, 32'h20, 32'h20);
      HEATSINK_TRIP <= 1'b1;
      @(negedge REF_CLK);
      chk(OUTPUT_OFF, 1'b1);
      @(posedge REF_CLK);
      HEATSINK_TRIP <= 1'b0;
      HEATSINK_TEMP <= 8'h19;
    end
    ripple_case(1'b0, 12'h002);
    ripple_case(1'b1, 12'h004);
    // leakage detection off, then on below and above the limit
    hw_reset();
    wr(OFS_PROTECT, 32'h0064_0032);
    leak <= 16'sh00c8;
    rdc(OFS_STATUS, 32'h10, 32'h0);
    @(negedge REF_CLK);
    chk(OUTPUT_OFF, 1'b0);
    @(posedge REF_CLK);
    leak <= 16'sh0032;
    wr(OFS_PROTECT, 32'h0064_0132);
    rdc(OFS_STATUS, 32'h10, 32'h0);
    leak <= 16'sh00c8;
    repeat (4) @(posedge REF_CLK);
    rdc(OFS_STATUS, 32'h10, 32'h10);
    @(negedge REF_CLK);
    chk(OUTPUT_OFF, 1'b1);
    chk(FAULT_CONTACT, 1'b1);
    close_out();
  end
  // cut a hang short well past the expected run length
  initial
  begin
    repeat (30000) @(posedge REF_CLK);
    num_errors++;
    close_out();
  end
endmodule : farp_tb_top

/* File: farp_top.sv */
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
// fault supervision, auto restart, heatsink, phase loss, leakage
module farp_top (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // axi4-lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // drive status
  input wire logic RUNNING,
  input wire logic [farp_pkg::NFAULT-1:0] FAULT_IN,
  input wire logic DIAG_OK,
  input wire logic ERROR_RESET,
  input wire logic HIGH_CLASS,
  // sensors
  input wire logic [7:0] HEATSINK_TEMP,
  input wire logic HEATSINK_TRIP,
  input wire logic RIPPLE_SCAN,
  input wire logic [11:0] RIPPLE_VOLT,
  input wire logic signed [15:0] CUR_U,
  input wire logic signed [15:0] CUR_V,
  input wire logic signed [15:0] CUR_W,
  // power stage and relays
  output logic OUTPUT_OFF,
  output logic RESTART_REQ,
  output logic SPEED_SEARCH,
  output logic [2:0] STOP_MODE,
  output logic STOP_REQ,
  output logic MINOR_FAULT,
  output logic SPEED_LIMIT_EN,
  output logic [7:0] SPEED_LIMIT,
  output logic FAULT_CONTACT,
  output logic RELAY_A,
  output logic RELAY_B
);
  import farp_pkg::*;
  typedef struct packed {
    logic [3:0] attempt_limit;
    logic fault_relay_sel;
    logic [10:0] window;
    logic [1:0] ride_sel;
    logic [7:0] pre_temp;
    logic [2:0] react;
    logic [7:0] speed_lim;
    logic [7:0] ripple_pct;
    logic leak_en;
    logic [15:0] leak_limit;
    logic [7:0] func_a;
    logic [7:0] func_b;
    farp_state_e st;
    logic [3:0] attempts;
    logic [17:0] retry_cyc;
    logic [22:0] tenth_cyc;
    logic [10:0] win_tenths;
    logic [12:0] ok_tenths;
    logic [15:0] latched;
    logic ph_fault;
    logic gf_fault;
    logic prealarm;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } farp_s;
  farp_s r;
  farp_s next_r;
  logic ripple_over;
  logic [17:0] leak_abs;
  logic [15:0] rip_limit;
  logic [15:0] elig;
  logic fault_any;
  // clamp a value into its legal range
  function automatic logic [10:0] clamp11(input logic [10:0] v, input logic [10:0] lo,
                                          input logic [10:0] hi);
    clamp11 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp11
  // relay function decode, used for both relays
  function automatic logic relay_fn(input logic [7:0] f, input logic in_restart,
                                    input logic pre);
    relay_fn = (f == FUNC_RESTART) ? in_restart : ((f == FUNC_PREALARM) ? pre : 1'b0);
  endfunction : relay_fn
  // ripple limit in volts: percent tenths of the trip level
  assign rip_limit = 16'(({12'h0, (HIGH_CLASS ? OV_TRIP_HIGH : OV_TRIP_LOW)}
                          * {16'h0, r.ripple_pct}) / {14'h0, PERMILLE});
  farp_ripple #(.DEPTH(SCAN_WINDOW), .W(12)) u_ripple (
    .REF_CLK(REF_CLK),
    .ARST_N(ARST_N),
    .scan(RIPPLE_SCAN),
    .ripple(RIPPLE_VOLT),
    .limit(rip_limit),
    .over(ripple_over)
  );
  // leakage estimate from the phase current sum
  always_comb
  begin
    logic signed [17:0] s;
    s = 18'(CUR_U) + 18'(CUR_V) + 18'(CUR_W);
    leak_abs = s[17] ? 18'(-s) : s;
  end
  // eligible faults; undervoltage only with ride-through 1 or 2
  always_comb
  begin
    elig = ELIGIBLE_MASK;
    elig[F_UV] = (r.ride_sel == 2'h1) || (r.ride_sel == 2'h2);
  end
  assign fault_any = |r.latched;
  // next state
  always_comb
  begin
    next_r = r;
    next_r.latched = r.latched | FAULT_IN;
    next_r.gf_fault = r.leak_en && (leak_abs > {2'h0, r.leak_limit});
    next_r.ph_fault = ripple_over;
    next_r.prealarm = HEATSINK_TEMP >= r.pre_temp;
    // fault-free run timer in tenths of a second
    next_r.tenth_cyc = r.tenth_cyc + 23'h1;
    if (r.tenth_cyc == 23'(TENTH_S_CYC - 1))
      next_r.tenth_cyc = '0;
    if (!RUNNING || fault_any || r.st != FARP_RUN)
      next_r.ok_tenths = '0;
    else if (r.tenth_cyc == 23'(TENTH_S_CYC - 1) && r.ok_tenths != 13'(RUN_OK_TENTHS))
      next_r.ok_tenths = r.ok_tenths + 13'h1;
    if (r.ok_tenths == 13'(RUN_OK_TENTHS))
      next_r.attempts = '0;
    unique case (r.st)
      FARP_RUN:
      begin
        if (fault_any)
        begin
          if ((r.latched & ~elig) != '0 || r.attempts >= r.attempt_limit)
            next_r.st = FARP_TRIP;
          else
          begin
            next_r.st = FARP_RETRY;
            next_r.attempts = r.attempts + 4'h1;
            next_r.retry_cyc = '0;
            next_r.win_tenths = '0;
          end
        end
      end
      FARP_RETRY:
      begin
        next_r.retry_cyc = r.retry_cyc + 18'h1;
        if (r.retry_cyc == 18'(RETRY_PERIOD_CYC - 1))
          next_r.retry_cyc = '0;
        if (r.tenth_cyc == 23'(TENTH_S_CYC - 1))
          next_r.win_tenths = r.win_tenths + 11'h1;
        if ((r.latched & ~elig) != '0)
          next_r.st = FARP_TRIP;
        else if (r.retry_cyc == 18'(RETRY_PERIOD_CYC - 1) && DIAG_OK)
        begin
          next_r.st = FARP_RUN;
          next_r.latched = FAULT_IN;
        end
        else if (r.win_tenths >= r.window)
          next_r.st = FARP_TRIP;
      end
      FARP_TRIP:
      begin
        if (ERROR_RESET)
        begin
          next_r.st = FARP_RUN;
          next_r.attempts = '0;
          next_r.latched = FAULT_IN;
        end
      end
      default:
        next_r.st = FARP_TRIP;
    endcase
    // detected faults latch after the clears above, so a same-cycle set wins
    if (r.gf_fault)
      next_r.latched[F_GF] = 1'b1;
    if (r.ph_fault)
      next_r.latched[F_PF] = 1'b1;
    // axi write channel
    if (AWVALID && !r.aw_hold)
    begin
      next_r.aw_hold = 1'b1;
      next_r.aw_addr = AWADDR;
    end
    if (WVALID && !r.w_hold)
    begin
      next_r.w_hold = 1'b1;
      next_r.w_data = WDATA;
    end
    if (r.aw_hold && r.w_hold && !r.bvalid)
    begin
      next_r.aw_hold = 1'b0;
      next_r.w_hold = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = AXI_OKAY;
      unique case (r.aw_addr)
        OFS_RESTART:
        begin
          next_r.attempt_limit = (r.w_data[3:0] > ATTEMPT_MAX) ? ATTEMPT_MAX
                                                                 : r.w_data[3:0];
          next_r.fault_relay_sel = r.w_data[4];
          next_r.window = clamp11(r.w_data[18:8], WINDOW_MIN, WINDOW_MAX);
          next_r.ride_sel = r.w_data[21:20];
        end
        OFS_HEAT:
        begin
          next_r.pre_temp = 8'(clamp11({3'h0, r.w_data[7:0]}, {3'h0, PRE_TEMP_MIN},
                                       {3'h0, PRE_TEMP_MAX}));
          next_r.react = (r.w_data[10:8] > REACT_DEF) ? REACT_DEF : r.w_data[10:8];
          next_r.speed_lim = (r.w_data[23:16] > SPEED_LIM_MAX) ? SPEED_LIM_MAX
                                                                : r.w_data[23:16];
        end
        OFS_PROTECT:
        begin
          next_r.ripple_pct = (r.w_data[7:0] > RIPPLE_MAX) ? RIPPLE_MAX
                                                            : r.w_data[7:0];
          next_r.leak_en = r.w_data[8];
          next_r.leak_limit = r.w_data[31:16];
        end
        OFS_RELAY:
        begin
          next_r.func_a = r.w_data[7:0];
          next_r.func_b = r.w_data[15:8];
        end
        default:
          next_r.bresp = AXI_SLVERR;
      endcase
    end
    if (r.bvalid && BREADY)
      next_r.bvalid = 1'b0;
    // axi read channel
    if (ARVALID && !r.rvalid)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp = AXI_OKAY;
      unique case (ARADDR)
        OFS_RESTART:
          next_r.rdata = {10'h0, r.ride_sel, 1'b0, r.window, 3'h0, r.fault_relay_sel,
                          r.attempt_limit};
        OFS_HEAT:
          next_r.rdata = {8'h0, r.speed_lim, 5'h0, r.react, r.pre_temp};
        OFS_PROTECT:
          next_r.rdata = {r.leak_limit, 7'h0, r.leak_en, r.ripple_pct};
        OFS_RELAY:
          next_r.rdata = {16'h0, r.func_b, r.func_a};
        OFS_STATUS:
          next_r.rdata = {r.latched, 4'h0, r.attempts, 2'h0, r.prealarm, r.gf_fault,
                          r.ph_fault, 1'b0, r.st};
        default:
        begin
          next_r.rdata = '0;
          next_r.rresp = AXI_SLVERR;
        end
      endcase
    end
    else if (r.rvalid && RREADY)
      next_r.rvalid = 1'b0;
  end
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      r <= '0;
      r.attempt_limit <= ATTEMPT_DEF;
      r.window <= WINDOW_DEF;
      r.pre_temp <= PRE_TEMP_DEF;
      r.react <= REACT_DEF;
      r.speed_lim <= SPEED_LIM_DEF;
      r.ripple_pct <= RIPPLE_DEF;
      r.leak_en <= 1'b1;
      r.leak_limit <= 16'hffff;
      r.st <= FARP_RUN;
    end
    else
      r <= next_r;
  end
  // bus outputs
  assign AWREADY = !r.aw_hold;
  assign WREADY = !r.w_hold;
  assign BVALID = r.bvalid;
  assign BRESP = r.bresp;
  assign ARREADY = !r.rvalid;
  assign RVALID = r.rvalid;
  assign RDATA = r.rdata;
  assign RRESP = r.rresp;
  // drive outputs
  logic pre_stop;
  assign pre_stop = r.prealarm && (r.react <= FARP_FAST);
  assign OUTPUT_OFF = HEATSINK_TRIP || r.st != FARP_RUN || r.gf_fault;
  assign RESTART_REQ = (r.st == FARP_RETRY) && DIAG_OK
                       && (r.retry_cyc == 18'(RETRY_PERIOD_CYC - 1));
  assign SPEED_SEARCH = RESTART_REQ;
  assign STOP_REQ = pre_stop || r.ph_fault;
  assign STOP_MODE = r.ph_fault ? FARP_COAST : r.react;
  assign MINOR_FAULT = r.prealarm && (r.react == FARP_SHOW);
  assign SPEED_LIMIT_EN = r.prealarm && (r.react == FARP_REDUCE);
  assign SPEED_LIMIT = r.speed_lim;
  assign FAULT_CONTACT = (r.st == FARP_TRIP) || pre_stop || r.gf_fault
                         || (r.st == FARP_RETRY && r.fault_relay_sel);
  assign RELAY_A = relay_fn(r.func_a, r.st == FARP_RETRY, r.prealarm);
  assign RELAY_B = relay_fn(r.func_b, r.st == FARP_RETRY, r.prealarm);
  // assertions
  sequence s_fault_seen;
    r.st == FARP_RUN && fault_any;
  endsequence
  a_trip_nonelig: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    s_fault_seen ##0 ((r.latched & ~elig) != '0) |=> r.st == FARP_TRIP) else $error("no trip");
  a_limit_trip: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    s_fault_seen ##0 (r.attempts >= r.attempt_limit) |=> r.st == FARP_TRIP) else $error("limit");
  a_retry_count: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (r.st == FARP_RETRY) |=> $stable(r.attempts)) else $error("count");
  a_reset_clear: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (r.st == FARP_TRIP && ERROR_RESET) |=> r.attempts == 4'h0) else $error("no clear");
  a_limit_range: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    r.attempt_limit <= ATTEMPT_MAX) else $error("limit range");
  a_uv_gate: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (r.ride_sel == 2'h0) |-> !elig[F_UV]) else $error("uv gate");
  a_heat_off: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    HEATSINK_TRIP |-> OUTPUT_OFF) else $error("heat trip");
  a_pre_set: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (HEATSINK_TEMP >= r.pre_temp) |=> r.prealarm) else $error("prealarm");
  a_leak_off: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !r.leak_en |=> !r.gf_fault) else $error("leak disabled");
  a_relay_sel: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (r.st == FARP_RETRY && !r.fault_relay_sel && !pre_stop && !r.gf_fault) |-> !FAULT_CONTACT)
    else $error("relay sel");
endmodule : farp_top
